// >>> verilog/esba_regs.svh
`ifndef ESBA_REGS_SVH
`define ESBA_REGS_SVH

// Per-framer register offsets
`define ESBA_OFF_RX_ALIGN        9'h064
`define ESBA_OFF_RX_NONALIGN     9'h065
`define ESBA_OFF_RX_INTL_ALIGN   9'h066
`define ESBA_OFF_RX_INTL_NONAL   9'h067
`define ESBA_OFF_RX_REMOTE_ALARM 9'h068
`define ESBA_OFF_RX_SPARE4       9'h069
`define ESBA_OFF_RX_SPARE5       9'h06A
`define ESBA_OFF_RX_SPARE6       9'h06B
`define ESBA_OFF_RX_SPARE7       9'h06C
`define ESBA_OFF_RX_SPARE8       9'h06D
`define ESBA_OFF_RX_SPARE_NOW    9'h06E
`define ESBA_OFF_RX_CODEWORD6    9'h06F
`define ESBA_OFF_SPARE_MON_EN    9'h070
`define ESBA_OFF_RX_LS2          9'h091
`define ESBA_OFF_RX_LS7          9'h096
`define ESBA_OFF_RX_IM7          9'h0A6
`define ESBA_OFF_TX_SRC_CTRL     9'h114
`define ESBA_OFF_TX_ALIGN        9'h164
`define ESBA_OFF_TX_NONALIGN     9'h165
`define ESBA_OFF_TX_INTL_ALIGN   9'h166
`define ESBA_OFF_TX_INTL_NONAL   9'h167
`define ESBA_OFF_TX_REMOTE_ALARM 9'h168
`define ESBA_OFF_TX_SPARE4       9'h169
`define ESBA_OFF_TX_SPARE5       9'h16A
`define ESBA_OFF_TX_SPARE6       9'h16B
`define ESBA_OFF_TX_SPARE7       9'h16C
`define ESBA_OFF_TX_SPARE8       9'h16D
`define ESBA_OFF_TX_LS1          9'h190

// Framer copy spacing: bits above the 9-bit offset select the framer
`define ESBA_FRAMER_SEL_MSB      10
`define ESBA_FRAMER_SEL_LSB      9

// Bit positions in the non-align timeslot-zero byte
`define ESBA_BIT_SI              7
`define ESBA_BIT_REMOTE_ALARM    5
`define ESBA_BIT_SPARE4          4
`define ESBA_BIT_SPARE5          3
`define ESBA_BIT_SPARE6          2
`define ESBA_BIT_SPARE7          1
`define ESBA_BIT_SPARE8          0

// Status bit positions
`define ESBA_LS2_ALIGN_FRAME     0
`define ESBA_LS2_MULTIFRAME      1
`define ESBA_LS7_SPARE_CHANGE    0
`define ESBA_LS7_CODEWORD6       1
`define ESBA_TX_LATCHED_STATUS_ONE_MULTIFRAME     3

// Source control bit positions
`define ESBA_SRC_SI_ALIGN        0
`define ESBA_SRC_SI_NONAL        1
`define ESBA_SRC_REMOTE_ALARM    2
`define ESBA_SRC_SPARE4          3

// Reset values and counts
`define ESBA_BYTE_ZERO           8'h00
`define ESBA_NIB_ZERO            4'h0
`define ESBA_DF_LAST             3'h7
`define ESBA_SMF_END_A           3'h3
`define ESBA_SMF_END_B           3'h7
`define ESBA_SMF_STABLE          2'h2
`define ESBA_SPARE_COUNT         5

`endif

// >>> verilog/esba_pkg.sv
package esba_pkg;
	typedef logic [7:0] esba_byte_t;
	typedef logic [8:0] esba_off_t;
	typedef logic [2:0] esba_df_idx_t;
	typedef logic [3:0] esba_nib_t;
endpackage

// >>> verilog/esba_top.sv
// How it works
// - Receive align and non-align registers capture timeslot-zero bytes every align-frame boundary.
// - Every such refresh sets the align-frame flag in receive latched status two.
// - Eight multiframe receive registers update together with the receive multiframe flag.
// - Transmit overhead registers replace only positions the source control selects.
// - Transmit multiframe registers (166h to 16Dh) are sampled each transmit multiframe, setting the transmit multiframe flag.
// - Without a host rewrite the held transmit values are sent again.
// - Monitor enable selects which spare positions are watched for change.
// - Change in an enabled spare position sets bit 0 of receive latched status seven.
// - That flag requests an interrupt only when mask seven bit 0 is set.
// - Offset 06Eh reads the present received value of each spare bit.
// - Codeword six updates after three stable submultiframes differing from the stored one.
// - Codeword six change sets status seven bit 1, with its own mask bit.
// - Each framer copy decodes at base plus (n-1) times 200 hex.
// - Latched flags clear only on a written one; a new event sets again.
// - Active-low interrupt is low while any unmasked flag of latched status seven is set.
`timescale 1ns/1ps
`include "esba_regs.svh"

module esba_top #(
	parameter logic [1:0] FRAMER_INDEX = 2'h0
) (
	input  wire logic                    sys_clk,
	input  wire logic                    arst_n,
	input  wire logic [10:0]             host_addr,
	input  wire logic [7:0]              host_wdata,
	input  wire logic                    host_wr,
	input  wire logic                    host_rd,
	output      logic [7:0]              host_rdata,
	input  wire logic                    rx_df_strobe,
	input  wire logic                    rx_mf_first,
	input  wire logic [7:0]              rx_align_byte,
	input  wire logic [7:0]              rx_nonalign_byte,
	input  wire logic                    tx_df_strobe,
	input  wire logic                    tx_mf_first,
	input  wire logic [7:0]              tx_align_in,
	input  wire logic [7:0]              tx_nonalign_in,
	output      logic [7:0]              tx_align_out,
	output      logic [7:0]              tx_nonalign_out,
	output      logic                    tx_out_valid,
	output      logic                    irq_out_n
);

	// Bit of an overhead register that belongs to double frame idx (first double frame in MSB)
	function automatic logic pick_bit(input esba_pkg::esba_byte_t r, input esba_pkg::esba_df_idx_t idx);
		pick_bit = r[3'h7 - idx];
	endfunction

	// Shift one new bit into a per-multiframe collector
	function automatic esba_pkg::esba_byte_t shift_in(input esba_pkg::esba_byte_t r, input logic b);
		shift_in = {r[6:0], b};
	endfunction

	esba_pkg::esba_off_t   off;
	logic                  hit;
	logic                  wr_hit;
	logic                  rd_hit;
	esba_pkg::esba_byte_t  rx_align_frame_bits_reg;
	esba_pkg::esba_byte_t  rx_nonalign_frame_bits_reg;
	esba_pkg::esba_byte_t  rx_intl_bits_align_reg;
	esba_pkg::esba_byte_t  rx_intl_bits_nonalign_reg;
	esba_pkg::esba_byte_t  rx_remote_alarm_bits_reg;
	esba_pkg::esba_byte_t  rx_spare_reg [`ESBA_SPARE_COUNT];
	esba_pkg::esba_byte_t  rx_spare_current_values_reg;
	esba_pkg::esba_nib_t   rx_codeword_six_reg;
	esba_pkg::esba_byte_t  spare_monitor_enable_reg;
	logic [1:0]            rx_ls2_reg;
	logic [1:0]            rx_ls7_reg;
	logic [1:0]            rx_irq_mask_seven_reg;
	esba_pkg::esba_byte_t  tx_spare_source_control_reg;
	esba_pkg::esba_byte_t  tx_align_frame_bits_reg;
	esba_pkg::esba_byte_t  tx_nonalign_frame_bits_reg;
	esba_pkg::esba_byte_t  tx_intl_bits_align_reg;
	esba_pkg::esba_byte_t  tx_intl_bits_nonalign_reg;
	esba_pkg::esba_byte_t  tx_remote_alarm_bits_reg;
	esba_pkg::esba_byte_t  tx_spare_reg [`ESBA_SPARE_COUNT];
	logic                  tx_ls1_mf_reg;

	// Receive collectors
	esba_pkg::esba_df_idx_t rx_idx_reg;
	esba_pkg::esba_df_idx_t rx_idx;
	esba_pkg::esba_byte_t  col_si_al_reg;
	esba_pkg::esba_byte_t  col_si_na_reg;
	esba_pkg::esba_byte_t  col_ra_reg;
	esba_pkg::esba_byte_t  col_sp_reg [`ESBA_SPARE_COUNT];
	logic                  rx_seen_reg;
	logic                  rx_mf_done;
	logic [4:0]            spare_now;
	logic [4:0]            spare_diff;
	logic                  spare_event;
	// Codeword six tracking
	esba_pkg::esba_nib_t   cw_col_reg;
	esba_pkg::esba_nib_t   cw_col_next;
	esba_pkg::esba_nib_t   cw_last_reg;
	logic [1:0]            cw_stable_reg;
	logic                  cw_smf_end;
	logic                  cw_event;
	// Transmit shadow
	esba_pkg::esba_byte_t  sh_al_reg;
	esba_pkg::esba_byte_t  sh_na_reg;
	esba_pkg::esba_byte_t  sh_ra_reg;
	esba_pkg::esba_byte_t  sh_sp_reg [`ESBA_SPARE_COUNT];
	esba_pkg::esba_df_idx_t tx_idx_reg;
	esba_pkg::esba_df_idx_t tx_idx;
	logic                  tx_mf_start;
	esba_pkg::esba_byte_t  use_al;
	esba_pkg::esba_byte_t  use_na;
	esba_pkg::esba_byte_t  use_ra;
	esba_pkg::esba_byte_t  use_sp [`ESBA_SPARE_COUNT];
	esba_pkg::esba_byte_t  tx_na_next;
	esba_pkg::esba_byte_t  tx_al_next;
	esba_pkg::esba_byte_t  rdata_next;

	// Address decode per framer copy
	assign off    = host_addr[8:0];
	assign hit    = host_addr[`ESBA_FRAMER_SEL_MSB:`ESBA_FRAMER_SEL_LSB] == FRAMER_INDEX;
	assign wr_hit = host_wr && hit;
	assign rd_hit = host_rd && hit;

	// Receive double-frame position
	assign rx_idx     = rx_mf_first ? 3'h0 : rx_idx_reg;
	assign rx_mf_done = rx_df_strobe && (rx_idx == `ESBA_DF_LAST);

	// Double-frame capture
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_align_frame_bits_reg     <= `ESBA_BYTE_ZERO;
			rx_nonalign_frame_bits_reg  <= `ESBA_BYTE_ZERO;
			rx_spare_current_values_reg <= `ESBA_BYTE_ZERO;
			rx_seen_reg                 <= 1'b0;
		end
		else if (rx_df_strobe)
		begin
			rx_align_frame_bits_reg     <= rx_align_byte;
			rx_nonalign_frame_bits_reg  <= rx_nonalign_byte;
			rx_spare_current_values_reg <= {3'h0, spare_now};
			rx_seen_reg                 <= 1'b1;
		end
	end

	// Multiframe position, collectors and their transfer into the visible registers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_idx_reg                <= 3'h0;
			col_si_al_reg             <= `ESBA_BYTE_ZERO;
			col_si_na_reg             <= `ESBA_BYTE_ZERO;
			col_ra_reg                <= `ESBA_BYTE_ZERO;
			rx_intl_bits_align_reg    <= `ESBA_BYTE_ZERO;
			rx_intl_bits_nonalign_reg <= `ESBA_BYTE_ZERO;
			rx_remote_alarm_bits_reg  <= `ESBA_BYTE_ZERO;
			for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
			begin
				col_sp_reg[i]   <= `ESBA_BYTE_ZERO;
				rx_spare_reg[i] <= `ESBA_BYTE_ZERO;
			end
		end
		else if (rx_df_strobe)
		begin
			rx_idx_reg    <= rx_idx + 3'h1;
			col_si_al_reg <= shift_in(col_si_al_reg, rx_align_byte[`ESBA_BIT_SI]);
			col_si_na_reg <= shift_in(col_si_na_reg, rx_nonalign_byte[`ESBA_BIT_SI]);
			col_ra_reg    <= shift_in(col_ra_reg, rx_nonalign_byte[`ESBA_BIT_REMOTE_ALARM]);
			for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
				col_sp_reg[i] <= shift_in(col_sp_reg[i], rx_nonalign_byte[`ESBA_BIT_SPARE4 - i]);
			if (rx_mf_done)
			begin
				// All eight move in the same edge so software never sees a mixed set
				rx_intl_bits_align_reg    <= shift_in(col_si_al_reg, rx_align_byte[`ESBA_BIT_SI]);
				rx_intl_bits_nonalign_reg <= shift_in(col_si_na_reg, rx_nonalign_byte[`ESBA_BIT_SI]);
				rx_remote_alarm_bits_reg  <= shift_in(col_ra_reg, rx_nonalign_byte[`ESBA_BIT_REMOTE_ALARM]);
				for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
					rx_spare_reg[i] <= shift_in(col_sp_reg[i], rx_nonalign_byte[`ESBA_BIT_SPARE4 - i]);
			end
		end
	end

	// Spare-bit change monitor
	assign spare_now   = rx_nonalign_byte[`ESBA_BIT_SPARE4:`ESBA_BIT_SPARE8];
	assign spare_diff  = (spare_now ^ rx_spare_current_values_reg[4:0]) & spare_monitor_enable_reg[4:0];
	assign spare_event = rx_df_strobe && rx_seen_reg && (|spare_diff);

	// Codeword six: four bits per submultiframe, qualified over three in a row
	assign cw_col_next = {cw_col_reg[2:0], rx_nonalign_byte[`ESBA_BIT_SPARE6]};
	assign cw_smf_end  = rx_df_strobe && (rx_idx == `ESBA_SMF_END_A || rx_idx == `ESBA_SMF_END_B);
	assign cw_event    = cw_smf_end && (cw_col_next == cw_last_reg) && (cw_stable_reg == `ESBA_SMF_STABLE - 2'h1)
		&& (cw_col_next != rx_codeword_six_reg);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cw_col_reg          <= `ESBA_NIB_ZERO;
			cw_last_reg         <= `ESBA_NIB_ZERO;
			cw_stable_reg       <= 2'h0;
			rx_codeword_six_reg <= `ESBA_NIB_ZERO;
		end
		else if (rx_df_strobe)
		begin
			cw_col_reg <= cw_col_next;
			if (cw_smf_end)
			begin
				cw_last_reg <= cw_col_next;
				// Count repeats, saturating; a differing word restarts the run
				if (cw_col_next != cw_last_reg)
					cw_stable_reg <= 2'h0;
				else if (cw_stable_reg != `ESBA_SMF_STABLE)
					cw_stable_reg <= cw_stable_reg + 2'h1;
				if (cw_event)
					rx_codeword_six_reg <= cw_col_next;
			end
		end
	end

	// Latched status and the interrupt it drives; set wins over a same-cycle clear
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_ls2_reg    <= 2'h0;
			rx_ls7_reg    <= 2'h0;
			tx_ls1_mf_reg <= 1'b0;
			irq_out_n     <= 1'b1;
		end
		else
		begin
			rx_ls2_reg[`ESBA_LS2_ALIGN_FRAME] <= rx_df_strobe || (rx_ls2_reg[`ESBA_LS2_ALIGN_FRAME]
				&& !(wr_hit && off == `ESBA_OFF_RX_LS2 && host_wdata[`ESBA_LS2_ALIGN_FRAME]));
			rx_ls2_reg[`ESBA_LS2_MULTIFRAME] <= rx_mf_done || (rx_ls2_reg[`ESBA_LS2_MULTIFRAME]
				&& !(wr_hit && off == `ESBA_OFF_RX_LS2 && host_wdata[`ESBA_LS2_MULTIFRAME]));
			rx_ls7_reg[`ESBA_LS7_SPARE_CHANGE] <= spare_event || (rx_ls7_reg[`ESBA_LS7_SPARE_CHANGE]
				&& !(wr_hit && off == `ESBA_OFF_RX_LS7 && host_wdata[`ESBA_LS7_SPARE_CHANGE]));
			rx_ls7_reg[`ESBA_LS7_CODEWORD6] <= cw_event || (rx_ls7_reg[`ESBA_LS7_CODEWORD6]
				&& !(wr_hit && off == `ESBA_OFF_RX_LS7 && host_wdata[`ESBA_LS7_CODEWORD6]));
			tx_ls1_mf_reg <= tx_mf_start || (tx_ls1_mf_reg
				&& !(wr_hit && off == `ESBA_OFF_TX_LS1 && host_wdata[`ESBA_TX_LATCHED_STATUS_ONE_MULTIFRAME]));
			irq_out_n <= !(|(rx_ls7_reg & rx_irq_mask_seven_reg));
		end
	end

	// Host-written control and transmit registers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			spare_monitor_enable_reg    <= `ESBA_BYTE_ZERO;
			rx_irq_mask_seven_reg       <= 2'h0;
			tx_spare_source_control_reg <= `ESBA_BYTE_ZERO;
			tx_align_frame_bits_reg     <= `ESBA_BYTE_ZERO;
			tx_nonalign_frame_bits_reg  <= `ESBA_BYTE_ZERO;
			tx_intl_bits_align_reg      <= `ESBA_BYTE_ZERO;
			tx_intl_bits_nonalign_reg   <= `ESBA_BYTE_ZERO;
			tx_remote_alarm_bits_reg    <= `ESBA_BYTE_ZERO;
			for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
				tx_spare_reg[i] <= `ESBA_BYTE_ZERO;
		end
		else if (wr_hit)
		begin
			unique case (off)
				`ESBA_OFF_SPARE_MON_EN:    spare_monitor_enable_reg    <= host_wdata;
				`ESBA_OFF_RX_IM7:          rx_irq_mask_seven_reg       <= host_wdata[1:0];
				`ESBA_OFF_TX_SRC_CTRL:     tx_spare_source_control_reg <= host_wdata;
				`ESBA_OFF_TX_ALIGN:        tx_align_frame_bits_reg     <= host_wdata;
				`ESBA_OFF_TX_NONALIGN:     tx_nonalign_frame_bits_reg  <= host_wdata;
				`ESBA_OFF_TX_INTL_ALIGN:   tx_intl_bits_align_reg      <= host_wdata;
				`ESBA_OFF_TX_INTL_NONAL:   tx_intl_bits_nonalign_reg   <= host_wdata;
				`ESBA_OFF_TX_REMOTE_ALARM: tx_remote_alarm_bits_reg    <= host_wdata;
				`ESBA_OFF_TX_SPARE4:       tx_spare_reg[0]             <= host_wdata;
				`ESBA_OFF_TX_SPARE5:       tx_spare_reg[1]             <= host_wdata;
				`ESBA_OFF_TX_SPARE6:       tx_spare_reg[2]             <= host_wdata;
				`ESBA_OFF_TX_SPARE7:       tx_spare_reg[3]             <= host_wdata;
				`ESBA_OFF_TX_SPARE8:       tx_spare_reg[4]             <= host_wdata;
				default:                   ;
			endcase
		end
	end

	// Transmit multiframe sampling; the shadow holds until the next multiframe
	assign tx_idx      = tx_mf_first ? 3'h0 : tx_idx_reg;
	assign tx_mf_start = tx_df_strobe && tx_mf_first;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_idx_reg <= 3'h0;
			sh_al_reg  <= `ESBA_BYTE_ZERO;
			sh_na_reg  <= `ESBA_BYTE_ZERO;
			sh_ra_reg  <= `ESBA_BYTE_ZERO;
			for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
				sh_sp_reg[i] <= `ESBA_BYTE_ZERO;
		end
		else if (tx_df_strobe)
		begin
			tx_idx_reg <= tx_idx + 3'h1;
			if (tx_mf_start)
			begin
				// Unwritten registers still hold last values, so they go out again
				sh_al_reg <= tx_intl_bits_align_reg;
				sh_na_reg <= tx_intl_bits_nonalign_reg;
				sh_ra_reg <= tx_remote_alarm_bits_reg;
				for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
					sh_sp_reg[i] <= tx_spare_reg[i];
			end
		end
	end

	// First double frame uses freshly sampled values, later ones the shadow
	always_comb
	begin
		use_al = tx_mf_start ? tx_intl_bits_align_reg : sh_al_reg;
		use_na = tx_mf_start ? tx_intl_bits_nonalign_reg : sh_na_reg;
		use_ra = tx_mf_start ? tx_remote_alarm_bits_reg : sh_ra_reg;
		for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
			use_sp[i] = tx_mf_start ? tx_spare_reg[i] : sh_sp_reg[i];
		tx_al_next = tx_align_in;
		tx_na_next = tx_nonalign_in;
		if (tx_spare_source_control_reg[`ESBA_SRC_SI_ALIGN])
			tx_al_next[`ESBA_BIT_SI] = pick_bit(use_al, tx_idx);
		if (tx_spare_source_control_reg[`ESBA_SRC_SI_NONAL])
			tx_na_next[`ESBA_BIT_SI] = pick_bit(use_na, tx_idx);
		if (tx_spare_source_control_reg[`ESBA_SRC_REMOTE_ALARM])
			tx_na_next[`ESBA_BIT_REMOTE_ALARM] = pick_bit(use_ra, tx_idx);
		for (int i = 0; i < `ESBA_SPARE_COUNT; i++)
			if (tx_spare_source_control_reg[`ESBA_SRC_SPARE4 + i])
				tx_na_next[`ESBA_BIT_SPARE4 - i] = pick_bit(use_sp[i], tx_idx);
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_align_out    <= `ESBA_BYTE_ZERO;
			tx_nonalign_out <= `ESBA_BYTE_ZERO;
			tx_out_valid    <= 1'b0;
		end
		else
		begin
			tx_out_valid <= tx_df_strobe;
			if (tx_df_strobe)
			begin
				tx_align_out    <= tx_al_next;
				tx_nonalign_out <= tx_na_next;
			end
		end
	end

	// Read mux; unmapped or other-framer addresses read zero
	always_comb
	begin
		unique case (off)
			`ESBA_OFF_RX_ALIGN:        rdata_next = rx_align_frame_bits_reg;
			`ESBA_OFF_RX_NONALIGN:     rdata_next = rx_nonalign_frame_bits_reg;
			`ESBA_OFF_RX_INTL_ALIGN:   rdata_next = rx_intl_bits_align_reg;
			`ESBA_OFF_RX_INTL_NONAL:   rdata_next = rx_intl_bits_nonalign_reg;
			`ESBA_OFF_RX_REMOTE_ALARM: rdata_next = rx_remote_alarm_bits_reg;
			`ESBA_OFF_RX_SPARE4:       rdata_next = rx_spare_reg[0];
			`ESBA_OFF_RX_SPARE5:       rdata_next = rx_spare_reg[1];
			`ESBA_OFF_RX_SPARE6:       rdata_next = rx_spare_reg[2];
			`ESBA_OFF_RX_SPARE7:       rdata_next = rx_spare_reg[3];
			`ESBA_OFF_RX_SPARE8:       rdata_next = rx_spare_reg[4];
			`ESBA_OFF_RX_SPARE_NOW:    rdata_next = rx_spare_current_values_reg;
			`ESBA_OFF_RX_CODEWORD6:    rdata_next = {4'h0, rx_codeword_six_reg};
			`ESBA_OFF_SPARE_MON_EN:    rdata_next = spare_monitor_enable_reg;
			`ESBA_OFF_RX_LS2:          rdata_next = {6'h00, rx_ls2_reg};
			`ESBA_OFF_RX_LS7:          rdata_next = {6'h00, rx_ls7_reg};
			`ESBA_OFF_RX_IM7:          rdata_next = {6'h00, rx_irq_mask_seven_reg};
			`ESBA_OFF_TX_SRC_CTRL:     rdata_next = tx_spare_source_control_reg;
			`ESBA_OFF_TX_ALIGN:        rdata_next = tx_align_frame_bits_reg;
			`ESBA_OFF_TX_NONALIGN:     rdata_next = tx_nonalign_frame_bits_reg;
			`ESBA_OFF_TX_INTL_ALIGN:   rdata_next = tx_intl_bits_align_reg;
			`ESBA_OFF_TX_INTL_NONAL:   rdata_next = tx_intl_bits_nonalign_reg;
			`ESBA_OFF_TX_REMOTE_ALARM: rdata_next = tx_remote_alarm_bits_reg;
			`ESBA_OFF_TX_SPARE4:       rdata_next = tx_spare_reg[0];
			`ESBA_OFF_TX_SPARE5:       rdata_next = tx_spare_reg[1];
			`ESBA_OFF_TX_SPARE6:       rdata_next = tx_spare_reg[2];
			`ESBA_OFF_TX_SPARE7:       rdata_next = tx_spare_reg[3];
			`ESBA_OFF_TX_SPARE8:       rdata_next = tx_spare_reg[4];
			`ESBA_OFF_TX_LS1:          rdata_next = {4'h0, tx_ls1_mf_reg, 3'h0};
			default:                   rdata_next = `ESBA_BYTE_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			host_rdata <= `ESBA_BYTE_ZERO;
		else
			host_rdata <= rd_hit ? rdata_next : `ESBA_BYTE_ZERO;
	end

endmodule

// >>> test/esba_top_asserts.sv
`timescale 1ns/1ps
module esba_top_asserts #(
	parameter logic [1:0] FRAMER_INDEX = 2'h0
) (
	input logic        sys_clk,
	input logic        arst_n,
	input logic [10:0] host_addr,
	input logic        host_wr,
	input logic        host_rd,
	input logic [7:0]  host_rdata,
	input logic        rx_df_strobe,
	input logic [7:0]  rx_nonalign_byte,
	input logic        tx_df_strobe,
	input logic [7:0]  tx_align_in,
	input logic [7:0]  tx_nonalign_in,
	input logic [7:0]  tx_align_out,
	input logic [7:0]  tx_nonalign_out,
	input logic        tx_out_valid,
	input logic        irq_out_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	rd_idle_a: assert property (!host_rd |=> host_rdata == 8'h00)
		else $error("read data not idle");
	other_framer_a: assert property (host_rd && host_addr[10:9] != FRAMER_INDEX |=> host_rdata == 8'h00)
		else $error("foreign framer answered");
	tx_valid_a: assert property (tx_df_strobe |=> tx_out_valid)
		else $error("no transmit valid");
	tx_hold_a: assert property (!tx_df_strobe |=> $stable(tx_align_out) && $stable(tx_nonalign_out))
		else $error("transmit bytes moved");
	tx_fixed_a: assert property (tx_df_strobe |=> tx_align_out[6:0] == $past(tx_align_in[6:0])
		&& tx_nonalign_out[6] == $past(tx_nonalign_in[6]))
		else $error("fixed bits replaced");
	spare_now_a: assert property (rx_df_strobe ##2 (host_rd && host_addr == {FRAMER_INDEX, 9'h06E})
		|=> host_rdata == {3'h0, $past(rx_nonalign_byte[4:0], 3)})
		else $error("spare values wrong");
	irq_set_a: assert property ($fell(irq_out_n) |-> $past(rx_df_strobe, 2) || $past(host_wr, 2))
		else $error("interrupt without cause");
	irq_release_a: assert property ($rose(irq_out_n) |-> $past(host_wr, 2))
		else $error("interrupt released alone");
endmodule
bind esba_top esba_top_asserts #(.FRAMER_INDEX(FRAMER_INDEX)) chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
	.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
	.rx_df_strobe(rx_df_strobe), .rx_nonalign_byte(rx_nonalign_byte), .tx_df_strobe(tx_df_strobe),
	.tx_align_in(tx_align_in), .tx_nonalign_in(tx_nonalign_in), .tx_align_out(tx_align_out),
	.tx_nonalign_out(tx_nonalign_out), .tx_out_valid(tx_out_valid), .irq_out_n(irq_out_n));

// >>> test/esba_line_model.sv
`timescale 1ns/1ps
module esba_line_model (
	input  logic       sys_clk,
	output logic       rx_df_strobe = 1'b0,
	output logic       rx_mf_first = 1'b0,
	output logic [7:0] rx_align_byte = 8'h00,
	output logic [7:0] rx_nonalign_byte = 8'h00,
	output logic       tx_df_strobe = 1'b0,
	output logic       tx_mf_first = 1'b0,
	output logic [7:0] tx_align_in = 8'h00,
	output logic [7:0] tx_nonalign_in = 8'h00
);
	// One double frame; bytes are inverted once the strobe is gone so stale data never looks valid
	task automatic frame(input logic tx, input logic f, input logic [7:0] a, input logic [7:0] n);
		@(posedge sys_clk);
		{rx_df_strobe, tx_df_strobe} <= {~tx, tx};
		{rx_mf_first, tx_mf_first} <= {f, f};
		{rx_align_byte, tx_align_in} <= {a, a};
		{rx_nonalign_byte, tx_nonalign_in} <= {n, n};
		@(posedge sys_clk);
		{rx_df_strobe, tx_df_strobe} <= 2'b00;
		{rx_mf_first, tx_mf_first} <= {~f, ~f};
		{rx_align_byte, tx_align_in} <= {~a, ~a};
		{rx_nonalign_byte, tx_nonalign_in} <= {~n, ~n};
	endtask
endmodule

// >>> test/e1_spare_bit_access_test.sv
`timescale 1ns/1ps
module e1_spare_bit_access_test;
	localparam logic [7:0] SI = 8'h3C;
	localparam logic [7:0] SA = 8'hA5;
	logic        sys_clk, rxs, rxf, txs, txf, tx_out_valid, irq_out_n;
	logic        arst_n = 1'b0;
	logic        host_wr = 1'b0;
	logic        host_rd = 1'b0;
	logic [10:0] host_addr = 11'h000;
	logic [7:0]  host_wdata = 8'h00;
	logic [7:0]  host_rdata, rxa, rxn, txa, txn, tx_align_out, tx_nonalign_out, e, b;
	logic [7:0]  tbl [8] = '{8'hD4, 8'h50, 8'hF4, 8'h41, 8'h94, 8'h12, 8'h5C, 8'h08};
	int          bad_count = 0;
	int          total_checks = 0;
	esba_top #(.FRAMER_INDEX(2'h1)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
		.rx_df_strobe(rxs), .rx_mf_first(rxf), .rx_align_byte(rxa), .rx_nonalign_byte(rxn),
		.tx_df_strobe(txs), .tx_mf_first(txf), .tx_align_in(txa), .tx_nonalign_in(txn),
		.tx_align_out(tx_align_out), .tx_nonalign_out(tx_nonalign_out), .tx_out_valid(tx_out_valid),
		.irq_out_n(irq_out_n));
	esba_line_model ln_u (.sys_clk(sys_clk), .rx_df_strobe(rxs), .rx_mf_first(rxf), .rx_align_byte(rxa),
		.rx_nonalign_byte(rxn), .tx_df_strobe(txs), .tx_mf_first(txf), .tx_align_in(txa), .tx_nonalign_in(txn));
	task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
		total_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", s, x, g);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		{host_addr, host_wdata, host_wr} <= {a, d, 1'b1};
		@(posedge sys_clk);
		host_wr <= 1'b0;
	endtask
	task automatic rd(input logic [10:0] a, input logic [7:0] x);
		@(posedge sys_clk);
		{host_addr, host_rd} <= {a, 1'b1};
		@(posedge sys_clk);
		host_rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), x, host_rdata);
	endtask
	task automatic irq(input logic x);
		@(posedge sys_clk);
		#1 chk("irq_out_n", {7'h00, x}, {7'h00, irq_out_n});
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Whole run is well under two thousand cycles
	initial
	begin
		#50000;
		bad_count++;
		give_verdict();
	end
	initial
	begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		irq(1'b1);
		rd(11'h291, 8'h00);
		wr(11'h2A6, 8'h02);
		wr(11'h264, 8'hFF);
		wr(11'h0A6, 8'h00);
		rd(11'h2A6, 8'h02);
		rd(11'h264, 8'h00);
		rd(11'h2FF, 8'h00);
		rd(11'h0A6, 8'h00);
		wr(11'h270, 8'h01);
		ln_u.frame(1'b0, 1'b1, 8'h9B, 8'h40);
		ln_u.frame(1'b0, 1'b0, 8'h9B, 8'h42);
		rd(11'h296, 8'h00);
		ln_u.frame(1'b0, 1'b0, 8'h9B, 8'h43);
		rd(11'h26E, 8'h03);
		rd(11'h296, 8'h01);
		irq(1'b1);
		wr(11'h2A6, 8'h03);
		irq(1'b0);
		wr(11'h296, 8'h00);
		rd(11'h296, 8'h01);
		wr(11'h296, 8'h01);
		irq(1'b1);
		rd(11'h265, 8'h43);
		rd(11'h291, 8'h01);
		wr(11'h291, 8'h03);
		wr(11'h270, 8'h00);
		for (int m = 0; m < 2; m++)
		begin
			for (int k = 0; k < 8; k++)
				ln_u.frame(1'b0, k == 0, ~tbl[k], tbl[k]);
			rd(11'h291, 8'h03);
			rd(11'h296, m ? 8'h02 : 8'h00);
			wr(11'h291, 8'h03);
		end
		rd(11'h26F, 8'h0A);
		irq(1'b0);
		for (int j = 0; j < 8; j++)
		begin
			e = 8'h00;
			for (int k = 0; k < 8; k++)
			begin
				b = (j == 0) ? ~tbl[k] : tbl[k];
				e = {e[6:0], b[(j < 2) ? 7 : 7 - j]};
			end
			rd(11'h266 + 11'(j), e);
		end
		wr(11'h314, 8'h09);
		wr(11'h366, SI);
		wr(11'h369, SA);
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 8; k++)
			begin
				ln_u.frame(1'b1, k == 0, tbl[k], ~tbl[k]);
				b = ~tbl[k];
				#1 chk("tx align", {SI[7 - k], tbl[k][6:0]}, tx_align_out);
				chk("tx nonalign", {b[7:5], SA[7 - k], b[3:0]}, tx_nonalign_out);
				if (k == 0)
				begin
					rd(11'h390, 8'h08);
					wr(11'h390, 8'h08);
				end
			end
		give_verdict();
	end
endmodule
